// *** core/exu_map.vh ***
`ifndef EXU_MAP_VH
`define EXU_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EXU_A_INSTR 8'h00
`define EXU_A_STATUS 8'h04
`define EXU_A_CTRL 8'h08
`define EXU_A_PC 8'h0C
`define EXU_A_ACCA_LO 8'h10
`define EXU_A_ACCA_HI 8'h14
`define EXU_A_ACCB_LO 8'h18
`define EXU_A_ACCB_HI 8'h1C
`define EXU_A_DEFAULT_WORK_REGISTER_BASE 8'h40

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define EXU_F_OP 4:0
`define EXU_F_WD 8:5
`define EXU_F_WS 12:9
`define EXU_F_WB 16:13
`define EXU_F_LIT 30:17
`define EXU_F_BYTE 31

// ----------------------------------------
// status flag positions
// ----------------------------------------
`define EXU_S_C 0
`define EXU_S_Z 1
`define EXU_S_OV 2
`define EXU_S_N 3
`define EXU_S_DC 4
`define EXU_S_OA 5
`define EXU_S_OB 6
`define EXU_S_SA 7
`define EXU_S_SB 8
`define EXU_S_OAB 9
`define EXU_S_SAB 10
`define EXU_S_BUSY 16
`define EXU_S_SP 28:24

// ----------------------------------------
// control bits and reset values
// ----------------------------------------
`define EXU_C_SATA 0
`define EXU_C_SATB 1
`define EXU_C_FASTRET 2
`define EXU_RST_CTRL 3'h0
`define EXU_RST_FLAGS 11'h000
`define EXU_RST_WORD 16'h0000

// ----------------------------------------
// opcodes
// ----------------------------------------
`define EXU_OP_NOP 5'h00
`define EXU_OP_MUL_UNSIGNED_UNSIGNED 5'h01
`define EXU_OP_MUL_UNSIGNED_UNSIGNED_LIT 5'h02
`define EXU_OP_POP_D 5'h03
`define EXU_OP_PUSH_D 5'h04
`define EXU_OP_RPT_LIT 5'h05
`define EXU_OP_RPT_REG 5'h06
`define EXU_OP_IRQ_RET 5'h07
`define EXU_OP_RET_LIT 5'h08
`define EXU_OP_RET 5'h09
`define EXU_OP_RLC 5'h0A
`define EXU_OP_ROTATE_LEFT_PLAIN 5'h0B
`define EXU_OP_RRC 5'h0C
`define EXU_OP_ROTATE_RIGHT_PLAIN 5'h0D
`define EXU_OP_SE 5'h0E
`define EXU_OP_ACC_ARITH_SHIFT 5'h0F
`define EXU_OP_SL_LIT 5'h10
`define EXU_OP_SUB_F 5'h11
`define EXU_OP_REVERSE_MINUS_F 5'h12
`define EXU_OP_SWAP 5'h13
`define EXU_OP_PROG_READ_HIGH 5'h14
`define EXU_OP_PROG_READ_LOW 5'h15
`define EXU_OP_PROG_WRITE_HIGH 5'h16
`define EXU_OP_TBLWTL 5'h17
`define EXU_OP_XOR_F 5'h18
`define EXU_OP_ZE 5'h19

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define EXU_CYC_ONE 2'h1
`define EXU_CYC_TWO 2'h2
`define EXU_CYC_THREE 2'h3

`endif

// *** core/exu_core.v ***
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "exu_map.vh"

module exu_core (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg exec_busy_r
);

// ----------------------------------------
// state
// ----------------------------------------
reg [15:0] w_r [0:15];
reg [15:0] stk_r [0:31];
reg [7:0] pm_hi_r [0:63];
reg [15:0] pm_lo_r [0:63];
reg [10:0] st_r;
reg [2:0] ctrl_r;
reg [4:0] sp_r;
reg [15:0] pc_r;
reg [39:0] acc_a_r;
reg [39:0] acc_b_r;
reg [31:0] ins_r;
reg [15:0] rpt_r;
reg [15:0] iter_r;
reg [1:0] cnt_r;
reg [7:0] awaddr_r;
reg aw_have_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg w_have_r;
integer i;

// ----------------------------------------
// helpers
// ----------------------------------------
function [18:0] sub16;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] d;
    begin
        d = {1'b0, a} - {1'b0, b};
        sub16 = {(a[3:0] >= b[3:0]), (a[15] ^ b[15]) & (a[15] ^ d[15]), ~d[16], d[15:0]};
    end
endfunction

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
                merge[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
    end
endfunction

function [1:0] cycles;
    input [4:0] op;
    input fast;
    begin
        case (op)
            `EXU_OP_POP_D, `EXU_OP_PUSH_D, `EXU_OP_PROG_READ_HIGH, `EXU_OP_PROG_READ_LOW,
            `EXU_OP_PROG_WRITE_HIGH, `EXU_OP_TBLWTL: cycles = `EXU_CYC_TWO;
            `EXU_OP_IRQ_RET, `EXU_OP_RET_LIT, `EXU_OP_RET:
                cycles = fast ? `EXU_CYC_TWO : `EXU_CYC_THREE;
            default: cycles = `EXU_CYC_ONE;
        endcase
    end
endfunction

function uniform;
    input [40:0] x;
    begin
        uniform = (&x) | ~(|x);
    end
endfunction

// ----------------------------------------
// operands and execution result
// ----------------------------------------
wire [4:0] op = ins_r[`EXU_F_OP];
wire [3:0] wd = ins_r[`EXU_F_WD];
wire [3:0] wd1 = wd + 4'h1;
wire [3:0] ws = ins_r[`EXU_F_WS];
wire [3:0] ws1 = ws + 4'h1;
wire [13:0] lit = ins_r[`EXU_F_LIT];
wire [15:0] vs = w_r[ws];
wire [3:0] wb_i = ins_r[`EXU_F_WB];
wire [15:0] vb = w_r[wb_i];
wire [15:0] v0 = w_r[0];
wire [5:0] pa_s = vs[5:0];
wire [5:0] pa_d = w_r[wd][5:0];
wire [4:0] sp_m1 = sp_r - 5'h01;
wire [4:0] sp_m2 = sp_r - 5'h02;
wire [18:0] sub_fw = sub16(vs, v0);
wire [18:0] sub_wf = sub16(v0, vs);
wire last = exec_busy_r && (cnt_r == 2'h0);

reg we_a;
reg we_b;
reg [15:0] da;
reg [15:0] db;
reg [10:0] st_nxt;
reg [4:0] sp_nxt;
reg push_we;
reg pc_we;
reg [15:0] pc_nxt;
reg acc_we;
reg [39:0] acc_nxt;
reg rpt_we;
reg [15:0] rpt_nxt;
reg [31:0] prod;
reg [39:0] acc_src;
reg [71:0] ext;
reg [5:0] neg_sh;
reg sat_en;
reg clip;

always @* begin
    we_a = 1'b0;
    we_b = 1'b0;
    da = `EXU_RST_WORD;
    db = `EXU_RST_WORD;
    st_nxt = st_r;
    sp_nxt = sp_r;
    push_we = 1'b0;
    pc_we = 1'b0;
    pc_nxt = stk_r[sp_m1];
    acc_we = 1'b0;
    acc_nxt = 40'h00_0000_0000;
    rpt_we = 1'b0;
    rpt_nxt = 16'h0000;
    prod = 32'h0000_0000;
    acc_src = lit[13] ? acc_b_r : acc_a_r;
    ext = 72'h00_0000_0000_0000_0000;
    neg_sh = 6'h00;
    sat_en = lit[13] ? ctrl_r[`EXU_C_SATB] : ctrl_r[`EXU_C_SATA];
    clip = 1'b0;
    case (op)
        `EXU_OP_MUL_UNSIGNED_UNSIGNED, `EXU_OP_MUL_UNSIGNED_UNSIGNED_LIT: begin
            prod = vb * ((op == `EXU_OP_MUL_UNSIGNED_UNSIGNED) ? vs : {11'h000, lit[4:0]});
            we_a = 1'b1;
            we_b = 1'b1;
            da = prod[15:0];
            db = prod[31:16];
        end
        `EXU_OP_POP_D: begin
            we_a = 1'b1;
            we_b = 1'b1;
            db = stk_r[sp_m1];
            da = stk_r[sp_m2];
            sp_nxt = sp_m2;
        end
        `EXU_OP_PUSH_D: begin
            push_we = 1'b1;
            sp_nxt = sp_r + 5'h02;
        end
        `EXU_OP_RPT_LIT: begin
            rpt_we = 1'b1;
            rpt_nxt = {2'h0, lit};
        end
        `EXU_OP_RPT_REG: begin
            rpt_we = 1'b1;
            rpt_nxt = vs;
        end
        `EXU_OP_IRQ_RET: begin
            pc_we = 1'b1;
            sp_nxt = sp_m2;
            st_nxt[`EXU_S_N] = stk_r[sp_m2][`EXU_S_N];
            st_nxt[`EXU_S_OV] = stk_r[sp_m2][`EXU_S_OV];
            st_nxt[`EXU_S_Z] = stk_r[sp_m2][`EXU_S_Z];
            st_nxt[`EXU_S_C] = stk_r[sp_m2][`EXU_S_C];
        end
        `EXU_OP_RET_LIT: begin
            pc_we = 1'b1;
            sp_nxt = sp_m1;
            we_a = 1'b1;
            da = {6'h00, lit[9:0]};
        end
        `EXU_OP_RET: begin
            pc_we = 1'b1;
            sp_nxt = sp_m1;
        end
        `EXU_OP_RLC: begin
            we_a = 1'b1;
            da = {vs[14:0], st_r[`EXU_S_C]};
            st_nxt[`EXU_S_C] = vs[15];
        end
        `EXU_OP_ROTATE_LEFT_PLAIN: begin
            we_a = 1'b1;
            da = {vs[14:0], vs[15]};
        end
        `EXU_OP_RRC: begin
            we_a = 1'b1;
            da = {st_r[`EXU_S_C], vs[15:1]};
            st_nxt[`EXU_S_C] = vs[0];
        end
        `EXU_OP_ROTATE_RIGHT_PLAIN: begin
            we_a = 1'b1;
            da = {vs[0], vs[15:1]};
        end
        `EXU_OP_SE: begin
            we_a = 1'b1;
            da = {{8{vs[7]}}, vs[7:0]};
            st_nxt[`EXU_S_C] = 1'b1;
        end
        `EXU_OP_ACC_ARITH_SHIFT: begin
            acc_we = 1'b1;
            neg_sh = ~lit[5:0] + 6'h01;
            ext = {{32{acc_src[39]}}, acc_src};
            if (lit[5]) begin
                ext = ext << neg_sh;
            end else begin
                ext = $signed(ext) >>> lit[5:0];
            end
            clip = sat_en && !uniform(ext[71:31]);
            if (clip) begin
                acc_nxt = ext[71] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF;
            end else begin
                acc_nxt = ext[39:0];
            end
            if (lit[13]) begin
                st_nxt[`EXU_S_OB] = !uniform({32'h0000_0000, acc_nxt[39:31]});
                st_nxt[`EXU_S_SB] = st_r[`EXU_S_SB] | clip;
            end else begin
                st_nxt[`EXU_S_OA] = !uniform({32'h0000_0000, acc_nxt[39:31]});
                st_nxt[`EXU_S_SA] = st_r[`EXU_S_SA] | clip;
            end
            st_nxt[`EXU_S_OAB] = st_nxt[`EXU_S_OA] | st_nxt[`EXU_S_OB];
            st_nxt[`EXU_S_SAB] = st_nxt[`EXU_S_SA] | st_nxt[`EXU_S_SB];
        end
        `EXU_OP_SL_LIT: begin
            we_a = 1'b1;
            da = vb << lit[3:0];
        end
        `EXU_OP_SUB_F: begin
            we_a = 1'b1;
            da = sub_fw[15:0];
            {st_nxt[`EXU_S_DC], st_nxt[`EXU_S_OV], st_nxt[`EXU_S_C]} = sub_fw[18:16];
        end
        `EXU_OP_REVERSE_MINUS_F: begin
            we_a = 1'b1;
            da = sub_wf[15:0];
            {st_nxt[`EXU_S_DC], st_nxt[`EXU_S_OV], st_nxt[`EXU_S_C]} = sub_wf[18:16];
        end
        `EXU_OP_SWAP: begin
            we_a = 1'b1;
            da = ins_r[`EXU_F_BYTE] ? {vs[15:8], vs[3:0], vs[7:4]} : {vs[7:0], vs[15:8]};
        end
        `EXU_OP_PROG_READ_HIGH: begin
            we_a = 1'b1;
            da = {8'h00, pm_hi_r[pa_s]};
        end
        `EXU_OP_PROG_READ_LOW: begin
            we_a = 1'b1;
            da = pm_lo_r[pa_s];
        end
        `EXU_OP_XOR_F: begin
            we_a = 1'b1;
            da = vs ^ v0;
        end
        `EXU_OP_ZE: begin
            we_a = 1'b1;
            da = {8'h00, vs[7:0]};
            st_nxt[`EXU_S_C] = 1'b1;
        end
        default: begin
            we_a = 1'b0;
        end
    endcase
    // N and Z from the written word
    case (op)
        `EXU_OP_RLC, `EXU_OP_ROTATE_LEFT_PLAIN, `EXU_OP_RRC, `EXU_OP_ROTATE_RIGHT_PLAIN, `EXU_OP_SE,
        `EXU_OP_SL_LIT, `EXU_OP_SUB_F, `EXU_OP_REVERSE_MINUS_F, `EXU_OP_XOR_F: begin
            st_nxt[`EXU_S_N] = da[15];
            st_nxt[`EXU_S_Z] = (da == 16'h0000);
        end
        `EXU_OP_ZE: begin
            st_nxt[`EXU_S_N] = 1'b0;
            st_nxt[`EXU_S_Z] = (da == 16'h0000);
        end
        default: begin
            st_nxt[`EXU_S_N] = st_nxt[`EXU_S_N];
        end
    endcase
end

// ----------------------------------------
// bus decode
// ----------------------------------------
wire w_fire = aw_have_r && w_have_r && !s_axi_bvalid;
wire [31:0] wm = merge(32'h0000_0000, wdata_r, wstrb_r);
wire w_is_reg = (awaddr_r[7:6] == 2'h1) && (awaddr_r[1:0] == 2'h0);
wire [3:0] w_idx = awaddr_r[5:2];
wire [31:0] m_lo = merge({16'h0000, (w_is_reg ? w_r[w_idx] : pc_r)}, wdata_r, wstrb_r);
wire [31:0] m_sc = merge({21'h000000, (awaddr_r[3] ? {8'h00, ctrl_r} : st_r)}, wdata_r, wstrb_r);
wire r_is_reg = (s_axi_araddr[7:6] == 2'h1) && (s_axi_araddr[1:0] == 2'h0);
reg w_ok;
reg r_ok;
reg [31:0] rd;

always @* begin
    case (awaddr_r)
        `EXU_A_INSTR, `EXU_A_STATUS, `EXU_A_CTRL, `EXU_A_PC, `EXU_A_ACCA_LO,
        `EXU_A_ACCA_HI, `EXU_A_ACCB_LO, `EXU_A_ACCB_HI: w_ok = 1'b1;
        default: w_ok = w_is_reg;
    endcase
    r_ok = 1'b1;
    rd = 32'h0000_0000;
    case (s_axi_araddr)
        `EXU_A_STATUS: begin
            rd[10:0] = st_r;
            rd[`EXU_S_BUSY] = exec_busy_r;
            rd[`EXU_S_SP] = sp_r;
        end
        `EXU_A_INSTR: rd = ins_r;
        `EXU_A_CTRL: rd[2:0] = ctrl_r;
        `EXU_A_PC: rd[15:0] = pc_r;
        `EXU_A_ACCA_LO: rd = acc_a_r[31:0];
        `EXU_A_ACCA_HI: rd[7:0] = acc_a_r[39:32];
        `EXU_A_ACCB_LO: rd = acc_b_r[31:0];
        `EXU_A_ACCB_HI: rd[7:0] = acc_b_r[39:32];
        default: begin
            r_ok = r_is_reg;
            rd[15:0] = r_is_reg ? w_r[s_axi_araddr[5:2]] : 16'h0000;
        end
    endcase
end

// ----------------------------------------
// bus slave and execution sequencer
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0000_0000;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
        exec_busy_r <= 1'b0;
        st_r <= `EXU_RST_FLAGS;
        ctrl_r <= `EXU_RST_CTRL;
        sp_r <= 5'h00;
        pc_r <= `EXU_RST_WORD;
        acc_a_r <= 40'h00_0000_0000;
        acc_b_r <= 40'h00_0000_0000;
        ins_r <= 32'h0000_0000;
        rpt_r <= `EXU_RST_WORD;
        iter_r <= `EXU_RST_WORD;
        cnt_r <= 2'h0;
        for (i = 0; i < 16; i = i + 1) begin
            w_r[i] <= `EXU_RST_WORD;
        end
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= r_ok ? 2'h0 : 2'h2;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        if (w_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? 2'h0 : 2'h2;
            case (awaddr_r)
                `EXU_A_INSTR: begin
                    if (!exec_busy_r) begin
                        ins_r <= wm;
                        exec_busy_r <= 1'b1;
                        cnt_r <= cycles(wm[`EXU_F_OP], ctrl_r[`EXU_C_FASTRET]) - 2'h1;
                        iter_r <= rpt_r;
                        rpt_r <= `EXU_RST_WORD;
                    end
                end
                `EXU_A_STATUS: st_r <= m_sc[10:0];
                `EXU_A_CTRL: ctrl_r <= m_sc[2:0];
                `EXU_A_PC: pc_r <= m_lo[15:0];
                `EXU_A_ACCA_LO: acc_a_r[31:0] <= merge(acc_a_r[31:0], wdata_r, wstrb_r);
                `EXU_A_ACCA_HI: acc_a_r[39:32] <= wstrb_r[0] ? wdata_r[7:0] : acc_a_r[39:32];
                `EXU_A_ACCB_LO: acc_b_r[31:0] <= merge(acc_b_r[31:0], wdata_r, wstrb_r);
                `EXU_A_ACCB_HI: acc_b_r[39:32] <= wstrb_r[0] ? wdata_r[7:0] : acc_b_r[39:32];
                default: begin
                    if (w_is_reg) begin
                        w_r[w_idx] <= m_lo[15:0];
                    end
                end
            endcase
        end
        // execution beats a same-cycle bus write
        if (exec_busy_r) begin
            if (cnt_r != 2'h0) begin
                cnt_r <= cnt_r - 2'h1;
            end else begin
                if (iter_r != 16'h0000) begin
                    iter_r <= iter_r - 16'h0001;
                    cnt_r <= cycles(op, ctrl_r[`EXU_C_FASTRET]) - 2'h1;
                end else begin
                    exec_busy_r <= 1'b0;
                end
            end
        end
        if (last) begin
            st_r <= st_nxt;
            sp_r <= sp_nxt;
            if (we_a) begin
                w_r[wd] <= da;
            end
            if (we_b) begin
                w_r[wd1] <= db;
            end
            if (pc_we) begin
                pc_r <= pc_nxt;
            end
            if (rpt_we) begin
                rpt_r <= rpt_nxt;
            end
            if (acc_we && lit[13]) begin
                acc_b_r <= acc_nxt;
            end
            if (acc_we && !lit[13]) begin
                acc_a_r <= acc_nxt;
            end
        end
    end
end

// ----------------------------------------
// stack and program memory writes
// ----------------------------------------
always @(posedge aclk) begin
    if (last && push_we) begin
        stk_r[sp_r] <= vs;
        stk_r[sp_r + 5'h01] <= w_r[ws1];
    end
    if (last && op == `EXU_OP_PROG_WRITE_HIGH) begin
        pm_hi_r[pa_d] <= vs[7:0];
    end
    if (last && op == `EXU_OP_TBLWTL) begin
        pm_lo_r[pa_d] <= vs;
    end
end

endmodule
`default_nettype wire

// *** testbench/exu_core_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "exu_map.vh"
module exu_core_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic exec_busy_r
);
    // ------
    // last two issued opcodes
    // ------
    logic [4:0] op_r;
    logic [4:0] prv_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            op_r <= 5'h00;
            prv_r <= 5'h00;
        end else if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00 && !exec_busy_r) begin
            prv_r <= op_r;
            op_r <= s_axi_wdata[4:0];
        end
    end
    wire rpt = prv_r == `EXU_OP_RPT_LIT || prv_r == `EXU_OP_RPT_REG;
    wire two = op_r == `EXU_OP_POP_D || op_r == `EXU_OP_PUSH_D || op_r[4:2] == 3'h5;
    wire ret = op_r >= `EXU_OP_IRQ_RET && op_r <= `EXU_OP_RET;
    // ------
    // properties
    // ------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_one_cycle: assert property ($rose(exec_busy_r) && !two && !ret && !rpt
        |=> !exec_busy_r) else $error("one-cycle length");
    a_two_cycle: assert property ($rose(exec_busy_r) && two && !rpt
        |=> exec_busy_r ##1 !exec_busy_r) else $error("two-cycle length");
    a_ret_cycles: assert property ($rose(exec_busy_r) && ret && !rpt
        |=> exec_busy_r ##[1:2] !exec_busy_r) else $error("return length wrong");
    a_busy_start: assert property ($rose(exec_busy_r) |-> $rose(s_axi_bvalid))
        else $error("busy without response");
    a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("b not released");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("r not released");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready while pending");
    a_b_after_both: assert property ($rose(s_axi_bvalid)
        |-> $past(!s_axi_awready && !s_axi_wready)) else $error("early response");
    cover property ($rose(exec_busy_r) && rpt);
    cover property ($rose(exec_busy_r) && two);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind exu_core exu_core_chk exu_core_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .exec_busy_r(exec_busy_r));
`default_nettype wire

// *** testbench/exu_core_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "exu_map.vh"
module exu_core_test;
    // ------
    // signals
    // ------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_busy_r;
    wire [1:0] s_axi_bresp;
    wire [1:0] s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    logic [31:0] d;
    logic [15:0] a, b, z;
    logic [13:0] lit;
    logic [10:0] f;
    logic [1:0] r;
    logic [42:0] e;
    logic [4:0] op;
    logic [4:0] ops [12] = '{5'h01, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
        5'h10, 5'h11, 5'h12, 5'h13, 5'h18, 5'h19};
    exu_core exu_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .exec_busy_r(exec_busy_r));
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    // ------
    // tasks
    // ------
    task summarize();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task rd(input logic [7:0] ad);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task run(input logic [31:0] ins);
        wr(`EXU_A_INSTR, ins);
        n = 0;
        while (exec_busy_r) begin
            n++;
            @(posedge aclk);
        end
    endtask
    function automatic logic [42:0] ref_op(input logic [4:0] o, input logic [15:0] p, q, w,
        input logic [13:0] l, input logic [10:0] fi);
        logic [16:0] s;
        logic [15:0] x;
        logic [10:0] g;
        g = fi;
        x = 16'h0000;
        case (o)
            5'h01: return {fi, 32'(p) * 32'(q)};
            5'h0A: {g[0], x} = {p, fi[0]};
            5'h0B: x = {p[14:0], p[15]};
            5'h0C: {x, g[0]} = {fi[0], p};
            5'h0D: x = {p[0], p[15:1]};
            5'h0E: {g[0], x} = {1'b1, {8{p[7]}}, p[7:0]};
            5'h10: x = q << l[3:0];
            5'h13: return {fi, 16'h0000, l[13] ? {p[15:8], p[3:0], p[7:4]} : {p[7:0], p[15:8]}};
            5'h18: x = p ^ w;
            5'h19: {g[0], x} = {9'h100, p[7:0]};
            default: begin
                if (o == 5'h12) {p, w} = {w, p};
                s = {1'b0, p} - {1'b0, w};
                x = s[15:0];
                g[0] = !s[16];
                g[4] = p[3:0] >= w[3:0];
                g[2] = (p[15] != w[15]) && (x[15] != p[15]);
            end
        endcase
        g[3] = x[15];
        g[1] = x == 16'h0000;
        return {g, 16'h0000, x};
    endfunction
    // ------
    // tests
    // ------
    initial begin
        void'($urandom(2));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`EXU_A_STATUS);
        chk("status reset", d, 32'h00000000);
        rd(8'h80);
        chk("unmapped read", {r, d[29:0]}, 32'h80000000);
        wr(8'h80, 32'h0000FFFF);
        chk("unmapped write", r, 2'h2);
        $display("bus test done");
        for (int i = 0; i < 36; i++) begin
            op = ops[i % 12];
            a = (i < 12) ? 16'h8000 : $urandom;
            b = $urandom;
            z = (i >= 24) ? a : $urandom;
            f = $urandom;
            lit = $urandom;
            wr(8'h40, z);
            wr(8'h48, a);
            wr(8'h4C, b);
            wr(8'h54, 0);
            wr(`EXU_A_STATUS, f);
            run({lit[13], lit, 4'h3, 4'h2, 4'h4, op});
            e = ref_op(op, a, b, z, lit, f);
            chk("alu cycles", n, 1);
            rd(8'h50);
            chk("alu low", d, e[15:0]);
            rd(8'h54);
            chk("alu high", d, e[31:16]);
            rd(`EXU_A_STATUS);
            chk("alu flags", d[10:0], e[42:32]);
        end
        $display("alu test done");
        for (int k = 0; k < 6; k++) begin
            a = $urandom;
            b = $urandom;
            f = $urandom;
            wr(8'h58, a);
            wr(8'h5C, b);
            wr(`EXU_A_STATUS, f);
            wr(`EXU_A_CTRL, (k >= 3) ? 32'h4 : 32'h0);
            run(32'h00000C04);
            chk("push cycles", n, 2);
            op = 5'h07 + k % 3;
            run({5'h00, a[9:0], 8'h00, 4'hE, op});
            chk("return cycles", n, (k < 3) ? 3 : 2);
            rd(`EXU_A_PC);
            chk("return pc", d, b);
            rd(`EXU_A_STATUS);
            chk("return flags", d[10:0], (op == 5'h07) ? {f[10:4], a[3:0]} : f);
            rd(8'h78);
            if (op == 5'h08) chk("return lit", d, a[9:0]);
        end
        run(32'h00000C04);
        run(32'h00000103);
        chk("pop cycles", n, 2);
        rd(8'h60);
        chk("pop low", d, a);
        rd(8'h64);
        chk("pop high", d, b);
        $display("stack test done");
        a = $urandom;
        z = $urandom;
        wr(8'h48, a);
        wr(8'h40, z);
        run(32'h00040005);
        chk("repeat cycles", n, 1);
        run(32'h00000451);
        chk("repeated cycles", n, 3);
        e = ref_op(5'h11, a - z - z, 16'h0000, z, 14'h0000, f);
        rd(8'h48);
        chk("repeat result", d, e[15:0]);
        rd(`EXU_A_STATUS);
        chk("repeat flags", d[10:0], e[42:32]);
        wr(8'h68, 32'h1);
        run(32'h00001406);
        run(32'h00000458);
        chk("reg repeat cycles", n, 2);
        rd(8'h48);
        chk("reg repeat result", d, e[15:0]);
        $display("repeat test done");
        b = $urandom;
        wr(8'h6C, b[5:0]);
        wr(8'h70, a);
        run(32'h00001976);
        chk("prog write cycles", n, 2);
        run(32'h00001977);
        run(32'h000017B4);
        chk("prog read cycles", n, 2);
        rd(8'h74);
        chk("prog high", d, a[7:0]);
        run(32'h000017B5);
        rd(8'h74);
        chk("prog low", d, a);
        rd(`EXU_A_STATUS);
        chk("prog flags", d[10:0], e[42:32]);
        wr(`EXU_A_ACCA_LO, 32'h40000000);
        wr(`EXU_A_STATUS, 32'h0);
        run(32'h007C000F);
        rd(`EXU_A_ACCA_HI);
        chk("acc high", d[7:0], 8'h01);
        rd(`EXU_A_STATUS);
        chk("acc flags", d[10:0], 11'h220);
        $display("acc test done");
        summarize();
    end
endmodule
`default_nettype wire
